// File: dv/midi_host_model.sv
`timescale 1ns/100ps
module midi_host_model (
  // Clock, reset and pacing.
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic slow_in,
  // Report byte stream.
  input wire logic valid_in,
  output logic ready_out
);
  // Answers an offered byte on the next cycle, or stalls on random cycles when pacing is slow.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) ready_out <= 1'b0;
    else ready_out <= valid_in && (!slow_in || ($urandom % 3 == 0));
  end
endmodule

// File: dv/sysex_fc_props.sv
`timescale 1ns/100ps
module sysex_fc_props
  import sysex_fc_pkg::*;
(
  // Clock and reset.
  input wire logic CORE_CLK_IN,
  input wire logic RESET_N_IN,
  // Report stream and settings.
  input wire logic TX_VALID_OUT,
  input wire logic [7:0] TX_DATA_OUT,
  input wire logic TX_READY_IN,
  input wire logic [3:0] MIDI_CHANNEL_IN,
  input wire logic OMNI_IN,
  input wire logic FREEZE_LOADED_IN,
  // Action outputs.
  input wire logic NAME_CLEAR_OUT,
  input wire logic [13:0] NAME_CLEAR_PROG_OUT,
  input wire logic UNDO_KEY_OUT,
  input wire logic COMPARE_KEY_OUT,
  input wire logic DECREMENT_KEY_OUT,
  input wire logic BUSY_OUT
);
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  logic [3:0] idx_ff;
  // Counts report bytes taken, so the class byte can be found by position.
  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) idx_ff <= 4'h0;
    else if (TX_VALID_OUT && TX_READY_IN) idx_ff <= (TX_DATA_OUT == EOX_BYTE) ? 4'h0 : idx_ff + 4'h1;
  end
  AST_CLEAR_RANGE: assert property (
    NAME_CLEAR_OUT |-> NAME_CLEAR_PROG_OUT >= 14'h007b && NAME_CLEAR_PROG_OUT <= 14'h00dd)
    else $error("clear outside user range");
  AST_CLEAR_REPORT: assert property (
    NAME_CLEAR_OUT |-> TX_VALID_OUT && BUSY_OUT && TX_DATA_OUT == SOX_BYTE)
    else $error("clear without report start");
  AST_UNDO_REPORT: assert property (
    UNDO_KEY_OUT |-> TX_VALID_OUT && TX_DATA_OUT == SOX_BYTE ##1 !UNDO_KEY_OUT)
    else $error("undo without report");
  AST_COMPARE_REPORT: assert property (
    $rose(COMPARE_KEY_OUT) |-> TX_VALID_OUT ##1 !COMPARE_KEY_OUT)
    else $error("compare without report");
  AST_EVENT_FREEZE: assert property (
    DECREMENT_KEY_OUT |-> $past(FREEZE_LOADED_IN) && !BUSY_OUT)
    else $error("event accepted wrongly");
  AST_CLASS_BYTE: assert property (
    TX_VALID_OUT && idx_ff == 4'h2 |->
      TX_DATA_OUT == {CLASS_CHANGE, OMNI_IN ? OMNI_NIBBLE : MIDI_CHANNEL_IN})
    else $error("bad report class byte");
  AST_HOLD: assert property (
    TX_VALID_OUT && !TX_READY_IN |=> TX_VALID_OUT && $stable(TX_DATA_OUT))
    else $error("report byte dropped");
  AST_END: assert property (
    TX_VALID_OUT && TX_READY_IN && TX_DATA_OUT == EOX_BYTE |=> !TX_VALID_OUT && !BUSY_OUT)
    else $error("report not closed");
  AST_ONE_ACTION: assert property (
    $onehot0({NAME_CLEAR_OUT, UNDO_KEY_OUT, COMPARE_KEY_OUT, DECREMENT_KEY_OUT}))
    else $error("two actions at once");
endmodule
bind sysex_function_call_handler sysex_fc_props i_sysex_fc_props (.CORE_CLK_IN, .RESET_N_IN,
  .TX_VALID_OUT, .TX_DATA_OUT, .TX_READY_IN, .MIDI_CHANNEL_IN, .OMNI_IN, .FREEZE_LOADED_IN,
  .NAME_CLEAR_OUT, .NAME_CLEAR_PROG_OUT, .UNDO_KEY_OUT, .COMPARE_KEY_OUT, .DECREMENT_KEY_OUT,
  .BUSY_OUT);

// File: dv/tb_sysex_function_call_handler.sv
`timescale 1ns/100ps
module tb_sysex_function_call_handler;
  import sysex_fc_pkg::*;
  localparam logic [7:0] ID_A = 8'h55; // Arbitrary value.
  localparam logic [7:0] ID_B = 8'h2a; // Arbitrary value.
  localparam logic [7:0] ID_C = 8'h33; // Arbitrary value.
  logic clk, rst_n, rx_valid, tx_valid, tx_ready, omni, frz, slow;
  logic clr, undo, cmp, dec, rec, press, busy, got_rec, got_press;
  logic [7:0] rx_data, tx_data;
  logic [3:0] chan, acts;
  logic [13:0] prog, got_prog;
  logic [7:0] exp_q[$];
  logic prot[int];
  int pn[4] = '{122, 123, 221, 222};
  int bad_count, compares, q;
  // Clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  sysex_function_call_handler #(.MAKER_ID(ID_A), .GROUP_ID(ID_B), .MODEL_ID(ID_C))
    i_sysex_function_call_handler (.CORE_CLK_IN(clk), .RESET_N_IN(rst_n),
    .RX_VALID_IN(rx_valid), .RX_DATA_IN(rx_data), .TX_VALID_OUT(tx_valid), .TX_DATA_OUT(tx_data),
    .TX_READY_IN(tx_ready), .MIDI_CHANNEL_IN(chan), .OMNI_IN(omni), .FREEZE_LOADED_IN(frz),
    .NAME_CLEAR_OUT(clr), .NAME_CLEAR_PROG_OUT(prog), .UNDO_KEY_OUT(undo),
    .COMPARE_KEY_OUT(cmp), .DECREMENT_KEY_OUT(dec), .EVENT_RECORD_OUT(rec),
    .KEY_PRESS_OUT(press), .BUSY_OUT(busy));
  midi_host_model i_midi_host_model (.clk_in(clk), .rst_n_in(rst_n), .slow_in(slow),
    .valid_in(tx_valid), .ready_out(tx_ready));
  task automatic check(input logic [13:0] seen, input logic [13:0] want);
    compares++;
    if (seen !== want) begin
      bad_count++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask
  task automatic end_of_test();
    $display("Compares %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Compares each report byte taken and latches the action pulses.
  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      if (exp_q.size() > 0) check(14'(tx_data), 14'(exp_q.pop_front()));
      else check(14'(tx_data), 14'h3fff);
    end
    if (clr) got_prog = prog;
    if (dec) got_rec = rec;
    if (dec) got_press = press;
    acts = acts | {clr, undo, cmp, dec};
  end
  // Sends one message, predicts its action and report, then compares both.
  task automatic call(input logic [3:0] cls, input logic [3:0] nib, input logic [7:0] a1,
                      input logic [7:0] a2, input int p, input logic dat, input logic [7:0] d2);
    logic [7:0] m[$];
    logic [3:0] ex;
    logic rep, ok;
    int n;
    // Settings driven by non-blocking assignment just before the call have landed here.
    @(negedge clk) acts = 4'h0;
    ex = 4'h0;
    rep = 1'b0;
    ok = omni || nib == chan;
    m = '{SOX_BYTE, ID_A, {cls, nib}, ID_B, ID_C, a1, a2, 8'(p >> 7), 8'(p & 127)};
    if (dat) m = {m, 8'h00, d2};
    m.push_back(EOX_BYTE);
    if (ok && cls == CLASS_CHANGE && a1 == ADDR_PROG_CALL && a2 == FUNC_CLEAR && !dat
        && p >= 123 && p <= 221) ex = 4'h8;
    if (ok && cls == CLASS_CHANGE && a1 == ADDR_KEY_CALL && p == 0 && dat && d2 == 0)
      ex = (a2 == FUNC_UNDO) ? 4'h4 : (a2 == FUNC_COMPARE) ? 4'h2 : 4'h0;
    if (ok && cls == CLASS_CHANGE && a1 == ADDR_EVENT_CALL && frz && a2 < 2 && p < 2 && dat
        && d2 == 0) ex = 4'h1;
    rep = ex[3] || ex[2] || ex[1];
    if (ok && a1 == ADDR_ATTR_CALL && a2 == FUNC_ATTR && p >= 1 && p <= 221
        && (cls == CLASS_QUERY ? !dat : cls == CLASS_CHANGE && dat && d2 < 2)) begin
      if (dat && p >= 123) prot[p] = d2[0];
      rep = 1'b1;
    end
    if (rep) begin
      exp_q = '{SOX_BYTE, ID_A, {CLASS_CHANGE, omni ? OMNI_NIBBLE : chan}, ID_B, ID_C, a1, a2,
                8'(p >> 7), 8'(p & 127)};
      if (a1 != ADDR_PROG_CALL) exp_q = {exp_q, 8'h00, 8'(prot.exists(p) ? prot[p] : 1'b0)};
      exp_q.push_back(EOX_BYTE);
    end
    foreach (m[i]) begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data <= m[i];
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    n = 0;
    while ((exp_q.size() > 0 || busy) && n < 300) begin
      @(posedge clk);
      n++;
    end
    repeat (3) @(posedge clk);
    check(14'(exp_q.size()), 14'h0);
    check(14'(acts), 14'(ex));
    if (ex[3]) check(got_prog, 14'(p));
    if (ex[0]) check(14'({got_rec, got_press}), 14'({a2[0], p[0]}));
  endtask
  // Watchdog against a hang.
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    end_of_test();
  end
  // Main sequence.
  initial begin
    rst_n = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    chan = 4'h0;
    omni = 1'b0;
    frz = 1'b1;
    slow = 1'b0;
    acts = 4'h0;
    bad_count = 0;
    compares = 0;
    void'($urandom(56379));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chan <= 4'($urandom);
    @(posedge clk);
    foreach (pn[i]) call(CLASS_CHANGE, chan, ADDR_PROG_CALL, FUNC_CLEAR, pn[i], 1'b0, 8'h00);
    call(CLASS_CHANGE, chan + 4'h1, ADDR_PROG_CALL, FUNC_CLEAR, 150, 1'b0, 8'h00);
    omni <= 1'b1;
    slow <= 1'b1;
    call(CLASS_CHANGE, 4'($urandom), ADDR_KEY_CALL, FUNC_UNDO, 0, 1'b1, 8'h00);
    call(CLASS_CHANGE, 4'($urandom), ADDR_KEY_CALL, FUNC_COMPARE, 0, 1'b1, 8'h00);
    call(CLASS_QUERY, 4'($urandom), ADDR_KEY_CALL, FUNC_UNDO, 0, 1'b1, 8'h00);
    omni <= 1'b0;
    for (int f = 0; f < 3; f++) begin
      for (int k = 0; k < 2; k++) call(CLASS_CHANGE, chan, ADDR_EVENT_CALL, 8'(f), k, 1'b1, 8'h00);
    end
    frz <= 1'b0;
    call(CLASS_CHANGE, chan, ADDR_EVENT_CALL, 8'h01, 1, 1'b1, 8'h00);
    q = 123 + $urandom % 99;
    call(CLASS_CHANGE, chan, ADDR_ATTR_CALL, FUNC_ATTR, q, 1'b1, 8'h01);
    call(CLASS_QUERY, chan, ADDR_ATTR_CALL, FUNC_ATTR, q, 1'b0, 8'h00);
    call(CLASS_CHANGE, chan, ADDR_ATTR_CALL, FUNC_ATTR, 100, 1'b1, 8'h01);
    call(CLASS_QUERY, chan, ADDR_ATTR_CALL, FUNC_ATTR, 100, 1'b0, 8'h00);
    call(CLASS_CHANGE, chan, ADDR_ATTR_CALL, FUNC_ATTR, q, 1'b1, 8'h00);
    call(CLASS_QUERY, chan, ADDR_ATTR_CALL, FUNC_ATTR, q, 1'b0, 8'h00);
    end_of_test();
  end
endmodule

// File: verilog/sysex_fc_pkg.sv
//----------------------------------------------------------------------
// Function
// R1 - Valid clear call erases addressed program name, then reports new state.
// R2 - Clear message: call address, clear function, number high/low, end, no data.
// R3 - Clear acts only on user programs 123 through 221.
// R4 - Reports use MIDI channel as device number; OMNI reports device number 1.
// R5 - Change class byte is 0001nnnn, nibble equals device number minus one.
// R6 - Undo call (0x11, 0x22, four zeros) acts as undo key, then reports.
// R7 - Compare call (0x11, 0x44, four zeros) acts as compare key, then reports.
// R8 - Event call accepted only with freeze effect loaded; acts as decrement key.
// R9 - Low nibble of event function: 0 freeze play, 1 freeze record.
// R10 - Event call for a mismatched effect type is ignored entirely.
// R11 - Event key-state byte 0 is release, 1 press; effect number byte zero.
// R12 - Attribute call (0x14, 0x04, number) sets protect, then reports.
// R13 - Attribute data 0x0001 protected, 0x0000 normal; programs 1-122 report only.
// R14 - Attribute query (class 0011nnnn, no data) answered by attribute change.
//----------------------------------------------------------------------
package sysex_fc_pkg;

  // Framing and class codes.
  localparam logic [7:0] SOX_BYTE = 8'hf0;
  localparam logic [7:0] EOX_BYTE = 8'hf7;
  localparam logic [3:0] CLASS_CHANGE = 4'h1;
  localparam logic [3:0] CLASS_QUERY = 4'h3;

  // Address bytes of the supported function calls.
  localparam logic [7:0] ADDR_PROG_CALL = 8'h10;
  localparam logic [7:0] FUNC_CLEAR = 8'h64;
  localparam logic [7:0] ADDR_KEY_CALL = 8'h11;
  localparam logic [7:0] FUNC_UNDO = 8'h22;
  localparam logic [7:0] FUNC_COMPARE = 8'h44;
  localparam logic [7:0] ADDR_EVENT_CALL = 8'h12;
  localparam logic [3:0] EVENT_PLAY = 4'h0;
  localparam logic [3:0] EVENT_RECORD = 4'h1;
  localparam logic [7:0] ADDR_ATTR_CALL = 8'h14;
  localparam logic [7:0] FUNC_ATTR = 8'h04;

  // Program number ranges.
  localparam logic [13:0] PROG_FIRST = 14'h0001;
  localparam logic [13:0] USER_FIRST = 14'h007b;
  localparam logic [13:0] PROG_LAST = 14'h00dd;

  // Body lengths between the start and end bytes.
  localparam logic [3:0] BODY_SHORT = 4'h8;
  localparam logic [3:0] BODY_LONG = 4'ha;

  // Device nibble used while the channel setting is OMNI.
  localparam logic [3:0] OMNI_NIBBLE = 4'h0;

  // Address, number and data bytes of a pending report.
  typedef struct packed {
    logic [7:0] addr_hi;
    logic [7:0] addr_lo;
    logic [7:0] num_hi;
    logic [7:0] num_lo;
    logic [7:0] data_hi;
    logic [7:0] data_lo;
    logic has_data;
  } report_t;

  typedef enum logic [1:0] {
    RX_HUNT = 2'b00,
    RX_BODY = 2'b01,
    RX_SKIP = 2'b10
  } rx_state_t;

  typedef enum logic {
    TX_IDLE = 1'b0,
    TX_SEND = 1'b1
  } tx_state_t;

endpackage

// File: verilog/sysex_function_call_handler.sv
`timescale 1ns/100ps
module sysex_function_call_handler
  import sysex_fc_pkg::*;
#(
  parameter logic [7:0] MAKER_ID = 8'h7d,   // Arbitrary value.
  parameter logic [7:0] GROUP_ID = 8'h01,   // Arbitrary value.
  parameter logic [7:0] MODEL_ID = 8'h02    // Arbitrary value.
) (
  // Clock and reset.
  input wire logic CORE_CLK_IN,
  input wire logic RESET_N_IN,
  // Received message bytes.
  input wire logic RX_VALID_IN,
  input wire logic [7:0] RX_DATA_IN,
  // Report bytes out.
  output logic TX_VALID_OUT,
  output logic [7:0] TX_DATA_OUT,
  input wire logic TX_READY_IN,
  // Device settings.
  input wire logic [3:0] MIDI_CHANNEL_IN,
  input wire logic OMNI_IN,
  input wire logic FREEZE_LOADED_IN,
  // Actions on the effect engine.
  output logic NAME_CLEAR_OUT,
  output logic [13:0] NAME_CLEAR_PROG_OUT,
  output logic UNDO_KEY_OUT,
  output logic COMPARE_KEY_OUT,
  output logic DECREMENT_KEY_OUT,
  output logic EVENT_RECORD_OUT,
  output logic KEY_PRESS_OUT,
  output logic BUSY_OUT
);

  //--------------------------------------------------------------------
  // Reset release
  //--------------------------------------------------------------------
  logic [1:0] rst_sync_ff;
  logic rst_n;

  // The reset is released through two flip-flops.
  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  //--------------------------------------------------------------------
  // Message capture
  //--------------------------------------------------------------------
  rx_state_t rx_state_ff;
  logic [3:0] rx_cnt_ff;
  logic [7:0] body_ff [0:9];
  tx_state_t tx_state_ff;

  // Bytes after the start byte are stored; a status byte ends the body.
  always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      rx_state_ff <= RX_HUNT;
      rx_cnt_ff <= 4'h0;
    end else if (RX_VALID_IN) begin
      if (RX_DATA_IN == SOX_BYTE) begin
        rx_state_ff <= RX_BODY;
        rx_cnt_ff <= 4'h0;
      end else if (RX_DATA_IN[7]) begin
        rx_state_ff <= RX_HUNT;
      end else if (rx_state_ff == RX_BODY) begin
        if (rx_cnt_ff == BODY_LONG) begin
          rx_state_ff <= RX_SKIP;   // Too long for any supported call.
        end else begin
          rx_cnt_ff <= rx_cnt_ff + 4'h1;
        end
      end
    end
  end

  // Body byte storage.
  always_ff @(posedge CORE_CLK_IN) begin
    if (RX_VALID_IN && !RX_DATA_IN[7] && rx_state_ff == RX_BODY &&
        rx_cnt_ff != BODY_LONG) begin
      body_ff[rx_cnt_ff] <= RX_DATA_IN;
    end
  end

  //--------------------------------------------------------------------
  // Decode
  //--------------------------------------------------------------------
  logic [3:0] dev_nibble;
  logic eom;
  logic hdr_ok;
  logic is_change;
  logic is_query;
  logic [13:0] prog;
  logic prog_ok;
  logic user_prog;
  logic data_zero;
  logic is_clear;
  logic is_undo;
  logic is_compare;
  logic is_event;
  logic is_attr_set;
  logic is_attr_query;
  logic accept;
  logic [255:0] protect_ff;
  logic attr_bit;

  // Device number is the channel, or 1 while OMNI.
  assign dev_nibble = OMNI_IN ? OMNI_NIBBLE : MIDI_CHANNEL_IN;   // R4
  assign eom = RX_VALID_IN && RX_DATA_IN == EOX_BYTE && rx_state_ff == RX_BODY;
  assign hdr_ok = body_ff[0] == MAKER_ID && body_ff[2] == GROUP_ID &&
                  body_ff[3] == MODEL_ID &&
                  (OMNI_IN || body_ff[1][3:0] == dev_nibble);
  assign is_change = body_ff[1][7:4] == CLASS_CHANGE;   // R5
  assign is_query = body_ff[1][7:4] == CLASS_QUERY;   // R14
  assign prog = {body_ff[6][6:0], body_ff[7][6:0]};
  assign prog_ok = prog >= PROG_FIRST && prog <= PROG_LAST;
  assign user_prog = prog >= USER_FIRST && prog <= PROG_LAST;   // R3
  assign data_zero = body_ff[8] == 8'h00 && body_ff[9] == 8'h00;

  // Clear call: address, function, number, no data.
  assign is_clear = is_change && rx_cnt_ff == BODY_SHORT &&
                    body_ff[4] == ADDR_PROG_CALL && body_ff[5] == FUNC_CLEAR &&
                    user_prog;   // R2 R3

  // Key calls carry four zero bytes.
  assign is_undo = is_change && rx_cnt_ff == BODY_LONG &&
                   body_ff[4] == ADDR_KEY_CALL && body_ff[5] == FUNC_UNDO &&
                   body_ff[6] == 8'h00 && body_ff[7] == 8'h00 && data_zero;   // R6
  assign is_compare = is_change && rx_cnt_ff == BODY_LONG &&
                      body_ff[4] == ADDR_KEY_CALL && body_ff[5] == FUNC_COMPARE &&
                      body_ff[6] == 8'h00 && body_ff[7] == 8'h00 && data_zero;   // R7

  // Event call only with a freeze effect and a known function.
  assign is_event = is_change && rx_cnt_ff == BODY_LONG &&
                    body_ff[4] == ADDR_EVENT_CALL && body_ff[5][7:4] == 4'h0 &&
                    (body_ff[5][3:0] == EVENT_PLAY || body_ff[5][3:0] == EVENT_RECORD) &&
                    body_ff[6] == 8'h00 && body_ff[7][7:1] == 7'h00 &&
                    body_ff[8] == 8'h00 && body_ff[9] == 8'h00 &&
                    FREEZE_LOADED_IN;   // R8 R9 R10 R11

  // Attribute calls and queries.
  assign is_attr_set = is_change && rx_cnt_ff == BODY_LONG &&
                       body_ff[4] == ADDR_ATTR_CALL && body_ff[5] == FUNC_ATTR &&
                       prog_ok && body_ff[8] == 8'h00 &&
                       body_ff[9][7:1] == 7'h00;   // R12 R13
  assign is_attr_query = is_query && rx_cnt_ff == BODY_SHORT &&
                         body_ff[4] == ADDR_ATTR_CALL && body_ff[5] == FUNC_ATTR &&
                         prog_ok;   // R14

  assign accept = eom && hdr_ok && tx_state_ff == TX_IDLE;

  // Reported protect value; read-only programs keep their stored value.
  assign attr_bit = (is_attr_set && user_prog) ? body_ff[9][0] :
                    protect_ff[prog[7:0]];   // R13

  //--------------------------------------------------------------------
  // Protect memory
  //--------------------------------------------------------------------
  always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      protect_ff <= '0;
    end else if (accept && is_attr_set && user_prog) begin
      protect_ff[prog[7:0]] <= body_ff[9][0];   // R12 R13
    end
  end

  //--------------------------------------------------------------------
  // Engine actions
  //--------------------------------------------------------------------
  // One-cycle action pulses.
  always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      NAME_CLEAR_OUT <= 1'b0;
      UNDO_KEY_OUT <= 1'b0;
      COMPARE_KEY_OUT <= 1'b0;
      DECREMENT_KEY_OUT <= 1'b0;
    end else begin
      NAME_CLEAR_OUT <= accept && is_clear;   // R1
      UNDO_KEY_OUT <= accept && is_undo;   // R6
      COMPARE_KEY_OUT <= accept && is_compare;   // R7
      DECREMENT_KEY_OUT <= accept && is_event;   // R8
    end
  end

  // Qualifiers that stand with the pulses until the next action of the same kind.
  always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      NAME_CLEAR_PROG_OUT <= 14'h0000;
      EVENT_RECORD_OUT <= 1'b0;
      KEY_PRESS_OUT <= 1'b0;
    end else if (accept && is_clear) begin
      NAME_CLEAR_PROG_OUT <= prog;
    end else if (accept && is_event) begin
      EVENT_RECORD_OUT <= body_ff[5][3:0] == EVENT_RECORD;   // R9
      KEY_PRESS_OUT <= body_ff[7][0];   // R11
    end
  end

  //--------------------------------------------------------------------
  // Report transmitter
  //--------------------------------------------------------------------
  report_t rep_ff;
  report_t nxt_rep;
  logic start;
  logic [3:0] tx_idx_ff;

  // Report contents for each accepted clear, key and attribute call; event calls send no report.
  always_comb begin
    nxt_rep = '0;
    start = 1'b0;
    if (is_clear) begin
      nxt_rep = {ADDR_PROG_CALL, FUNC_CLEAR, body_ff[6], body_ff[7], 16'h0000, 1'b0};   // R1
      start = 1'b1;
    end else if (is_undo || is_compare) begin
      nxt_rep = {ADDR_KEY_CALL, body_ff[5], 32'h00000000, 1'b1};   // R6 R7
      start = 1'b1;
    end else if (is_attr_set || is_attr_query) begin
      nxt_rep = {ADDR_ATTR_CALL, FUNC_ATTR, body_ff[6], body_ff[7], 8'h00,
                 {7'h00, attr_bit}, 1'b1};   // R12 R14
      start = 1'b1;
    end
  end

  // Byte of the report at a given position.
  function automatic logic [7:0] report_byte(input report_t r, input logic [3:0] idx,
                                             input logic [3:0] nib);
    logic [7:0] b;
    b = EOX_BYTE;
    unique case (idx)
      4'h1: b = MAKER_ID;
      4'h2: b = {CLASS_CHANGE, nib};   // R5
      4'h3: b = GROUP_ID;
      4'h4: b = MODEL_ID;
      4'h5: b = r.addr_hi;
      4'h6: b = r.addr_lo;
      4'h7: b = r.num_hi;
      4'h8: b = r.num_lo;
      4'h9: b = r.has_data ? r.data_hi : EOX_BYTE;
      4'ha: b = r.data_lo;
      default: b = EOX_BYTE;
    endcase
    return b;
  endfunction

  // Report latch.
  always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      rep_ff <= '0;
    end else if (accept && start) begin
      rep_ff <= nxt_rep;
    end
  end

  // Byte sequencer with a valid and ready handshake.
  always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      tx_state_ff <= TX_IDLE;
      tx_idx_ff <= 4'h0;
      TX_VALID_OUT <= 1'b0;
      TX_DATA_OUT <= 8'h00;
      BUSY_OUT <= 1'b0;
    end else begin
      unique case (tx_state_ff)
        TX_IDLE: begin
          if (accept && start) begin
            tx_state_ff <= TX_SEND;
            tx_idx_ff <= 4'h1;
            TX_VALID_OUT <= 1'b1;
            TX_DATA_OUT <= SOX_BYTE;
            BUSY_OUT <= 1'b1;
          end
        end
        TX_SEND: begin
          if (TX_READY_IN) begin
            if (TX_DATA_OUT == EOX_BYTE) begin
              tx_state_ff <= TX_IDLE;
              TX_VALID_OUT <= 1'b0;
              BUSY_OUT <= 1'b0;
            end else begin
              TX_DATA_OUT <= report_byte(rep_ff, tx_idx_ff, dev_nibble);   // R4
              tx_idx_ff <= tx_idx_ff + 4'h1;
            end
          end
        end
      endcase
    end
  end

endmodule
